// ### design/space_decode_consts.svh
// Constants for the descriptor output-space decoder and translate-op checker.
// Assumes inclusion by the design module and the bench only.
`ifndef SPACE_DECODE_CONSTS_SVH
`define SPACE_DECODE_CONSTS_SVH
// ----------------------------------------------------------------------
// Descriptor bit positions
// ----------------------------------------------------------------------
`define TABLE_OVERRIDE_BIT   63
`define S2_SPACE_BIT         55
`define S1_SPACE_BIT         5
`define EL3_EXT_BIT          11
// ----------------------------------------------------------------------
// Register map (plain port, word index)
// ----------------------------------------------------------------------
`define ADDR_W               4
`define ADDR_CTRL            4'h0
`define ADDR_SECCFG          4'h1
`define ADDR_RESULT          4'h2
`define ADDR_STATUS          4'h3
`define ADDR_RESET_REQ       4'h4
`define ADDR_VECTOR          4'h5
`define CTRL_RESET           32'h0000_0000
`define SECCFG_RESET         32'h0000_0000
`define VECTOR_RESET         32'h0000_0000
// ----------------------------------------------------------------------
// Fault status codes reported in the result register
// ----------------------------------------------------------------------
`define FST_NONE             6'h00
`define FST_GPF              6'h28
`define FST_GPT_SIZE         6'h29
`define FST_GPT_WALK         6'h2a
`define FST_GPT_EXT          6'h2b
`define FST_BASE_FAULT       6'h04
`endif

// ### design/space_decode_pkg.sv
// Types for the descriptor output-space decoder.
// Assumes space_decode_consts.svh is on the include path.
package space_decode_pkg;
	// Physical address spaces
	typedef enum logic [1:0] {
		SPACE_SECURE    = 2'h0,
		SPACE_NONSECURE = 2'h1,
		SPACE_ROOT      = 2'h2,
		SPACE_REALM     = 2'h3
	} space_e;

	// Translation regimes the walker may be in
	typedef enum logic [2:0] {
		REG_NS_EL10  = 3'h0,
		REG_S_EL10   = 3'h1,
		REG_RL_EL10  = 3'h2,
		REG_RL_EL2   = 3'h3,
		REG_RL_EL20  = 3'h4,
		REG_EL3      = 3'h5,
		REG_NS_EL2   = 3'h6,
		REG_S_EL2    = 3'h7
	} regime_e;

	// Descriptor arriving from the table walk
	typedef struct packed {
		logic        valid;
		logic [63:0] data;
		logic        is_table;
		logic        stage2;
		regime_e     regime;
		space_e      table_space;
	} desc_s;

	// Decoded leaf / table outcome
	typedef struct packed {
		logic        valid;
		space_e      space;
		logic        not_global_flag;
		logic        security_extension_select;
		logic        rsvd_bit_set;
	} decode_s;

	// Translate-op request
	typedef struct packed {
		logic       valid;
		logic [1:0] cur_el;
		logic [1:0] target_el;
		logic       stage1_el01_op;
		logic       fault;
		logic [1:0] gpc_kind;
		logic       gpc_on_s2_fetch;
		logic       gpc_on_s1_fetch;
		logic       gpc_would_except;
		logic       gpc_on_final_oa;
		logic [51:0] out_addr;
	} at_req_s;

	// Translate-op outcome
	typedef enum logic [3:0] {
		AT_IDLE   = 4'h1,
		AT_UNDEF  = 4'h2,
		AT_EXCEPT = 4'h4,
		AT_RECORD = 4'h8
	} at_state_e;

	// Invalidation request
	typedef struct packed {
		logic       valid;
		logic [1:0] cur_el;
		logic [1:0] target_el;
		space_e     cur_space;
	} tlb_invalidate_op_s;

	// Whole module state
	typedef struct packed {
		decode_s    dec;
		at_state_e  at_st;
		logic [63:0] result;
		logic        tlb_invalidate_op_valid;
		space_e      tlb_invalidate_op_space;
		logic        af_update;
		logic        dirty_update;
		logic [31:0] ctrl;
		logic [31:0] seccfg;
		logic [31:0] vector;
		logic        pe_reset;
		logic        reset_denied;
		logic [31:0] rdata;
	} state_s;
endpackage

// ### design/space_decode.sv
// Descriptor output-space decoder, invalidation scoping, translate-op checks.
// Assumes walk descriptors and requests arrive synchronous to clk_sys_in.
//
// The register addresses and the strobed register port are this design's own decisions.
`include "space_decode_consts.svh"

module space_decode (
	// Clock and reset
	input  wire logic                      clk_sys_in,
	input  wire logic                      rst_n_in,
	// Register port
	input  wire logic [`ADDR_W-1:0]        reg_addr_in,
	input  wire logic [31:0]               reg_wdata_in,
	input  wire logic                      reg_wr_in,
	input  wire logic                      reg_rd_in,
	input  wire logic [1:0]                reg_el_in,
	output logic      [31:0]               reg_rdata_out,
	// Walk descriptor
	input  wire space_decode_pkg::desc_s   desc_in,
	output space_decode_pkg::decode_s      decode_out,
	// Hardware update permissions
	input  wire logic                      af_request_in,
	input  wire logic                      dirty_request_in,
	input  wire logic                      final_stage_in,
	output logic                           af_update_out,
	output logic                           dirty_update_out,
	// Invalidation
	input  wire space_decode_pkg::tlb_invalidate_op_s   tlb_invalidate_op_in,
	output logic                           tlb_invalidate_op_valid_out,
	output space_decode_pkg::space_e       tlb_invalidate_op_space_out,
	// Translate op
	input  wire space_decode_pkg::at_req_s at_in,
	output space_decode_pkg::at_state_e    at_state_out,
	// Reset outputs
	output logic                           pe_reset_out,
	output logic                           mmu_el3_enable_out,
	output space_decode_pkg::space_e       vector_space_out,
	output logic      [31:0]               vector_addr_out
);

	space_decode_pkg::state_s state_reg;
	space_decode_pkg::state_s state_next;

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	// Space chosen from the two security configuration bits
	function automatic space_decode_pkg::space_e cfg_space(input logic ext, input logic ns);
		case ({ext, ns})
			2'b00:   cfg_space = space_decode_pkg::SPACE_SECURE;
			2'b01:   cfg_space = space_decode_pkg::SPACE_NONSECURE;
			2'b11:   cfg_space = space_decode_pkg::SPACE_REALM;
			default: cfg_space = space_decode_pkg::SPACE_ROOT;
		endcase
	endfunction

	function automatic logic is_realm(input space_decode_pkg::regime_e r);
		is_realm = (r == space_decode_pkg::REG_RL_EL10) || (r == space_decode_pkg::REG_RL_EL2) ||
			(r == space_decode_pkg::REG_RL_EL20);
	endfunction

	function automatic logic two_ranges(input space_decode_pkg::regime_e r);
		two_ranges = (r == space_decode_pkg::REG_NS_EL10) || (r == space_decode_pkg::REG_S_EL10) ||
			(r == space_decode_pkg::REG_RL_EL10) || (r == space_decode_pkg::REG_RL_EL20);
	endfunction

	// Default space of a regime when no select field applies
	function automatic space_decode_pkg::space_e home_space(input space_decode_pkg::regime_e r);
		case (r)
			space_decode_pkg::REG_NS_EL10, space_decode_pkg::REG_NS_EL2:
				home_space = space_decode_pkg::SPACE_NONSECURE;
			space_decode_pkg::REG_S_EL10, space_decode_pkg::REG_S_EL2:
				home_space = space_decode_pkg::SPACE_SECURE;
			space_decode_pkg::REG_EL3:
				home_space = space_decode_pkg::SPACE_ROOT;
			default:
				home_space = space_decode_pkg::SPACE_REALM;
		endcase
	endfunction

	logic el3_ctx;
	logic cfg_ext;
	logic cfg_ns;
	logic route_bit;
	assign el3_ctx   = (reg_el_in == 2'h3);
	assign cfg_ext   = state_reg.seccfg[1];
	assign cfg_ns    = state_reg.seccfg[0];
	assign route_bit = state_reg.seccfg[2];

	// ----------------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------------
	// Single combinational copy of the whole state
	always_comb begin
		logic [63:0] d;
		space_decode_pkg::regime_e rg;
		d  = desc_in.data;
		rg = desc_in.regime;
		state_next = state_reg;
		state_next.dec.valid = desc_in.valid;
		state_next.dec.rsvd_bit_set = 1'b0;
		state_next.dec.not_global_flag = 1'b0;
		state_next.dec.security_extension_select = 1'b0;
		state_next.dec.space = home_space(rg);
		if (desc_in.is_table) begin
			// No table-level override anywhere; bit 63 only flagged
			state_next.dec.rsvd_bit_set = d[`TABLE_OVERRIDE_BIT];
			state_next.dec.space = home_space(rg);
		end else if (desc_in.stage2) begin
			if (is_realm(rg)) begin
				// Realm stage 2 honours bit 55
				state_next.dec.space = d[`S2_SPACE_BIT] ? space_decode_pkg::SPACE_NONSECURE :
					space_decode_pkg::SPACE_REALM;
			end else begin
				state_next.dec.space = home_space(rg); // Bit 55 ignored
			end
		end else begin
			if ((rg == space_decode_pkg::REG_RL_EL2) || (rg == space_decode_pkg::REG_RL_EL20)) begin
				// Realm hypervisor stage 1 honours bit 5
				state_next.dec.space = d[`S1_SPACE_BIT] ? space_decode_pkg::SPACE_NONSECURE :
					space_decode_pkg::SPACE_REALM;
			end else if (rg == space_decode_pkg::REG_RL_EL10) begin
				// Realm guest stage 1 outputs an IPA, bit 5 reserved
				state_next.dec.rsvd_bit_set = d[`S1_SPACE_BIT];
				state_next.dec.space = space_decode_pkg::SPACE_REALM;
			end else if (rg == space_decode_pkg::REG_EL3) begin
				// Bit 11 paired with bit 5 picks one of four spaces
				state_next.dec.security_extension_select = d[`EL3_EXT_BIT];
				state_next.dec.space = cfg_space(d[`EL3_EXT_BIT], d[`S1_SPACE_BIT]);
			end
			if (two_ranges(rg)) begin
				state_next.dec.not_global_flag = d[`EL3_EXT_BIT];
			end
		end

		// Hardware updates are not gated by the protection check result
		state_next.af_update = af_request_in;
		state_next.dirty_update = dirty_request_in & final_stage_in;

		// Invalidation scope
		state_next.tlb_invalidate_op_valid = tlb_invalidate_op_in.valid;
		if (tlb_invalidate_op_in.cur_el == 2'h3 && tlb_invalidate_op_in.target_el != 2'h3) begin
			state_next.tlb_invalidate_op_space = cfg_space(cfg_ext, cfg_ns);
		end else if (tlb_invalidate_op_in.cur_space == space_decode_pkg::SPACE_REALM) begin
			state_next.tlb_invalidate_op_space = space_decode_pkg::SPACE_REALM;
		end else begin
			state_next.tlb_invalidate_op_space = tlb_invalidate_op_in.cur_space;
		end
		if (tlb_invalidate_op_in.cur_el == 2'h3 && tlb_invalidate_op_in.target_el != 2'h3 && cfg_ext && !cfg_ns) begin
			state_next.tlb_invalidate_op_valid = 1'b0; // Reserved config selects no state
		end

		// Translate op outcome
		state_next.at_st = space_decode_pkg::AT_IDLE;
		if (at_in.valid) begin
			if (at_in.cur_el == 2'h3 && at_in.target_el != 2'h3 && cfg_ext && !cfg_ns) begin
				state_next.at_st = space_decode_pkg::AT_UNDEF;
			end else if (at_in.fault && at_in.gpc_kind == 2'h0 && (at_in.gpc_would_except ||
				(at_in.stage1_el01_op && at_in.cur_el == 2'h1 && at_in.gpc_on_s2_fetch))) begin
				state_next.at_st = space_decode_pkg::AT_EXCEPT;
			end else if (at_in.fault && at_in.gpc_kind == 2'h0 && route_bit &&
				at_in.stage1_el01_op && at_in.cur_el == 2'h1 && at_in.gpc_on_s1_fetch) begin
				state_next.at_st = space_decode_pkg::AT_EXCEPT;
			end else begin
				state_next.at_st = space_decode_pkg::AT_RECORD;
				if (at_in.fault) begin
					// Fault code into status field, bit 0 flags failure
					state_next.result = 64'h0;
					state_next.result[0] = 1'b1;
					case (at_in.gpc_kind)
						2'h0:    state_next.result[6:1] = (at_in.gpc_on_s1_fetch ||
							at_in.gpc_on_s2_fetch) ? `FST_GPF : `FST_BASE_FAULT;
						2'h1:    state_next.result[6:1] = `FST_GPT_SIZE;
						2'h2:    state_next.result[6:1] = `FST_GPT_WALK;
						default: state_next.result[6:1] = `FST_GPT_EXT;
					endcase
				end else begin
					// Final output address unchecked on success
					state_next.result = {at_in.out_addr, 12'h000};
				end
			end
		end

		// Register writes; reset control only from EL3
		state_next.pe_reset = 1'b0;
		state_next.reset_denied = state_reg.reset_denied;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`ADDR_CTRL:   state_next.ctrl = reg_wdata_in;
				`ADDR_SECCFG: if (el3_ctx) state_next.seccfg = reg_wdata_in;
				`ADDR_VECTOR: if (el3_ctx) state_next.vector = reg_wdata_in;
				`ADDR_RESET_REQ: begin
					if (el3_ctx) begin
						state_next.pe_reset = reg_wdata_in[0];
					end else begin
						state_next.reset_denied = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// Denied flag: new event wins over read clear
		if (reg_rd_in && reg_addr_in == `ADDR_STATUS && !(reg_wr_in && !el3_ctx)) begin
			state_next.reset_denied = 1'b0;
		end

		// Read data, one cycle later
		case (reg_addr_in)
			`ADDR_CTRL:   state_next.rdata = state_reg.ctrl;
			`ADDR_SECCFG: state_next.rdata = state_reg.seccfg;
			`ADDR_RESULT: state_next.rdata = state_reg.result[31:0];
			`ADDR_STATUS: state_next.rdata = {24'h0, state_reg.at_st,
				state_reg.dec.space, state_reg.reset_denied, 1'b0};
			`ADDR_VECTOR: state_next.rdata = state_reg.vector;
			default:      state_next.rdata = 32'h0;
		endcase
		if (!reg_rd_in) begin
			state_next.rdata = 32'h0;
		end
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	// Control register resets with EL3 MMU off
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
			state_reg.at_st <= space_decode_pkg::AT_IDLE;
			state_reg.ctrl <= `CTRL_RESET;
			state_reg.seccfg <= `SECCFG_RESET;
			state_reg.vector <= `VECTOR_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	assign reg_rdata_out      = state_reg.rdata;
	assign decode_out         = state_reg.dec;
	assign af_update_out      = state_reg.af_update;
	assign dirty_update_out   = state_reg.dirty_update;
	assign tlb_invalidate_op_valid_out     = state_reg.tlb_invalidate_op_valid;
	assign tlb_invalidate_op_space_out     = state_reg.tlb_invalidate_op_space;
	assign at_state_out       = state_reg.at_st;
	assign pe_reset_out       = state_reg.pe_reset;
	assign mmu_el3_enable_out = state_reg.ctrl[0];
	// MMU off means flat map into root space
	assign vector_space_out   = state_reg.ctrl[0] ? space_decode_pkg::SPACE_REALM :
		space_decode_pkg::SPACE_ROOT;
	assign vector_addr_out    = state_reg.vector;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	a_table_no_override: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		desc_in.valid && desc_in.is_table |=> decode_out.space == home_space($past(desc_in.regime)))
		else $error("table descriptor changed output space");
	a_el3_table_root: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		desc_in.valid && desc_in.is_table && desc_in.regime == space_decode_pkg::REG_EL3
		|=> decode_out.space == space_decode_pkg::SPACE_ROOT)
		else $error("EL3 table not in root space");
	a_s2_realm_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		desc_in.valid && !desc_in.is_table && desc_in.stage2 &&
		desc_in.regime == space_decode_pkg::REG_RL_EL10 && desc_in.data[`S2_SPACE_BIT]
		|=> decode_out.space == space_decode_pkg::SPACE_NONSECURE)
		else $error("realm stage 2 select ignored");
	a_s2_ns_ignore: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		desc_in.valid && desc_in.stage2 && desc_in.regime == space_decode_pkg::REG_NS_EL10
		|=> decode_out.space == space_decode_pkg::SPACE_NONSECURE)
		else $error("non-realm stage 2 bit 55 used");
	a_guest_s1_realm: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		desc_in.valid && !desc_in.stage2 && desc_in.regime == space_decode_pkg::REG_RL_EL10
		|=> decode_out.space == space_decode_pkg::SPACE_REALM)
		else $error("realm guest stage 1 left realm space");
	a_tlb_invalidate_op_realm: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		tlb_invalidate_op_in.valid && tlb_invalidate_op_in.cur_el != 2'h3 && tlb_invalidate_op_in.cur_space == space_decode_pkg::SPACE_REALM
		|=> tlb_invalidate_op_valid_out && tlb_invalidate_op_space_out == space_decode_pkg::SPACE_REALM)
		else $error("realm invalidation out of scope");
	a_at_undef: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		at_in.valid && at_in.cur_el == 2'h3 && at_in.target_el != 2'h3 && cfg_ext && !cfg_ns
		|=> at_state_out == space_decode_pkg::AT_UNDEF)
		else $error("reserved config translate not undefined");
	a_reset_el3_only: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		pe_reset_out |-> $past(reg_wr_in) && $past(reg_el_in) == 2'h3 &&
		$past(reg_addr_in) == `ADDR_RESET_REQ)
		else $error("PE reset without EL3 write");
	a_fault_record: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		at_state_out == space_decode_pkg::AT_RECORD && $past(at_in.fault) |-> state_reg.result[0])
		else $error("recorded fault lacks failure flag");
endmodule

// ### verif/table_mem.sv
// Behavioural table memory that answers descriptor fetches for the decoder.
// Assumes fetches are issued one cycle at a time on clk_sys_in.
module table_mem (
	// Clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_n_in,
	// Table load and fetch
	input  wire logic                    load_in,
	input  wire logic                    fetch_in,
	input  wire logic [2:0]              idx_in,
	input  wire logic [63:0]             wdata_in,
	input  wire space_decode_pkg::desc_s ctx_in,
	// Returned descriptor
	output space_decode_pkg::desc_s      desc_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [63:0] mem [8];

	// Table storage, loaded by the bench
	always_ff @(posedge clk_sys_in) begin
		if (load_in) begin
			mem[idx_in] <= wdata_in;
		end
	end

	// One-cycle answer; between fetches the data lines invert on every edge, alternating
	// between the last word and its inverse, and valid stays low so a stale descriptor can never look valid
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			desc_out <= '0;
		end else begin
			desc_out <= ctx_in;
			desc_out.valid <= fetch_in;
			desc_out.data <= fetch_in ? mem[idx_in] : ~desc_out.data;
		end
	end
endmodule

// ### verif/space_decode_bench.sv
// Self-checking bench for the output-space decoder and translate-op checks.
// Assumes space_decode_consts.svh on the include path and table_mem compiled first.
`include "space_decode_consts.svh"

module space_decode_bench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed { logic [63:0] e; logic [63:0] m; } note_s;
	localparam space_decode_pkg::space_e sp_rl = space_decode_pkg::SPACE_REALM;
	localparam space_decode_pkg::space_e sp_ns = space_decode_pkg::SPACE_NONSECURE;
	localparam logic [63:0] b63 = 64'h8000_0000_0000_0000;
	localparam logic [63:0] b55 = 64'h0080_0000_0000_0000;

	logic                           clk_sys_in, rst_n_in, reg_wr, reg_rd, load, fetch;
	logic                           af_req, dirty_req, final_st, af_upd, dirty_upd, pe_rst;
	logic                           mmu_on, tlb_invalidate_op_v, rd_seen, af_cap, dirty_cap;
	logic [3:0]                     reg_addr;
	logic [31:0]                    reg_wdata, rdata, vec_addr, vec_w;
	logic [1:0]                     reg_el;
	logic [2:0]                     idx;
	logic [63:0]                    wdata, rng;
	space_decode_pkg::desc_s        ctx, desc;
	space_decode_pkg::decode_s      dec;
	space_decode_pkg::tlb_invalidate_op_s        tlb_invalidate_op_in;
	space_decode_pkg::space_e       tlb_invalidate_op_sp, vec_sp;
	space_decode_pkg::at_req_s      at_in;
	space_decode_pkg::at_state_e    at_st;
	note_s                          q_rd[$], q_dec[$], q_tlb_invalidate_op[$], q_at[$], q_rst[$];
	int                             mismatches = 0;
	int                             n_tests = 0;

	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	table_mem u_table_mem (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .load_in(load),
		.fetch_in(fetch), .idx_in(idx), .wdata_in(wdata), .ctx_in(ctx), .desc_out(desc));
	space_decode u_space_decode (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_el_in(reg_el), .reg_rdata_out(rdata), .desc_in(desc),
		.decode_out(dec), .af_request_in(af_req), .dirty_request_in(dirty_req),
		.final_stage_in(final_st), .af_update_out(af_upd), .dirty_update_out(dirty_upd),
		.tlb_invalidate_op_in(tlb_invalidate_op_in), .tlb_invalidate_op_valid_out(tlb_invalidate_op_v), .tlb_invalidate_op_space_out(tlb_invalidate_op_sp), .at_in(at_in),
		.at_state_out(at_st), .pe_reset_out(pe_rst), .mmu_el3_enable_out(mmu_on),
		.vector_space_out(vec_sp), .vector_addr_out(vec_addr));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [63:0] xs(input logic [63:0] s);
		logic [63:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 7);
		return x ^ (x << 17);
	endfunction

	function automatic logic [5:0] mk(input space_decode_pkg::space_e s, input logic ng,
		input logic ext, input logic rsv);
		return {1'b1, s, ng, ext, rsv};
	endfunction

	task automatic check(input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// An output with no note waiting counts as a mismatch
	task automatic take(ref note_s q[$], input logic [63:0] v);
		note_s n;
		n = (q.size() > 0) ? q.pop_front() : note_s'{~v, '1};
		check(v & n.m, n.e & n.m);
	endtask

	task automatic conclude();
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Drivers; each ends one edge after dropping its strobe
	// ------------------------------------------------------------
	task automatic reg_write(input logic [1:0] el, input logic [3:0] a, input logic [31:0] d);
		reg_el <= el;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q_rd.push_back('{64'(e), 64'(m)});
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	// Load a descriptor with random filler, fetch it, note the decode
	task automatic walk(input logic [63:0] d, input int r, input logic tbl, input logic s2,
		input logic [5:0] e, input logic [5:0] m);
		load <= 1'b1;
		idx <= rng[2:0];
		wdata <= (rng & 64'h7f7f_ffff_ffff_f7df) | d;
		ctx.regime <= space_decode_pkg::regime_e'(r);
		ctx.is_table <= tbl;
		ctx.stage2 <= s2;
		@(posedge clk_sys_in);
		load <= 1'b0;
		fetch <= 1'b1;
		q_dec.push_back('{64'(e), 64'(m)});
		@(posedge clk_sys_in);
		fetch <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic tlb_invalidate_op(input logic [1:0] el, input space_decode_pkg::space_e cur,
		input space_decode_pkg::space_e e, input logic hit);
		tlb_invalidate_op_in <= '{1'b1, el, 2'h1, cur};
		if (hit) begin
			q_tlb_invalidate_op.push_back('{64'(e), '1});
		end
		@(posedge clk_sys_in);
		tlb_invalidate_op_in <= '0;
		@(posedge clk_sys_in);
	endtask

	// Recorded outcomes are read back from the result register
	task automatic at_op(input logic [1:0] el, input logic [1:0] tgt, input logic s2f,
		input logic s1f, input logic exc, input logic fin, input logic [1:0] kind,
		input space_decode_pkg::at_state_e st);
		space_decode_pkg::at_req_s a;
		a = '0;
		a.valid = 1'b1;
		a.cur_el = el;
		a.target_el = tgt;
		a.stage1_el01_op = 1'b1;
		a.fault = s2f | s1f | exc;
		a.gpc_kind = kind;
		a.gpc_on_s2_fetch = s2f;
		a.gpc_on_s1_fetch = s1f;
		a.gpc_would_except = exc;
		a.gpc_on_final_oa = fin;
		a.out_addr = 52'(rng);
		at_in <= a;
		q_at.push_back('{64'(st), '1});
		@(posedge clk_sys_in);
		at_in <= '0;
		@(posedge clk_sys_in);
		if (st == space_decode_pkg::AT_RECORD) begin
			reg_read(`ADDR_RESULT, a.fault ? {25'h0, `FST_GPF + 6'(kind), 1'b1}
				: {a.out_addr[19:0], 12'h0}, '1);
		end
	endtask

	// ------------------------------------------------------------
	// Clock, random source, watcher, watchdog
	// ------------------------------------------------------------
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// Random update requests once out of reset
	always @(posedge clk_sys_in) begin
		rng <= xs(rng);
		if (rst_n_in === 1'b1) begin
			{af_req, dirty_req, final_st} <= rng[2:0];
		end
	end

	// Outputs are settled at the falling edge; each result takes the oldest note
	always @(negedge clk_sys_in) begin
		if (rst_n_in === 1'b1) begin
			if (rd_seen === 1'b1) take(q_rd, 64'(rdata));
			if (dec.valid === 1'b1) take(q_dec, 64'(dec));
			if (tlb_invalidate_op_v === 1'b1) take(q_tlb_invalidate_op, 64'(tlb_invalidate_op_sp));
			if (at_st !== space_decode_pkg::AT_IDLE) take(q_at, 64'(at_st));
			if (pe_rst === 1'b1) take(q_rst, 64'h1);
			check(64'(af_upd), 64'(af_cap));
			check(64'(dirty_upd), 64'(dirty_cap));
		end
		rd_seen = reg_rd;
		af_cap = af_req;
		dirty_cap = dirty_req & final_st;
	end

	initial begin
		repeat (20000) @(posedge clk_sys_in);
		mismatches++;
		conclude();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{reg_wr, reg_rd, load, fetch, af_req, dirty_req, final_st, rd_seen} = '0;
		{reg_addr, reg_wdata, reg_el, idx, wdata} = '0;
		{ctx, tlb_invalidate_op_in, at_in, af_cap, dirty_cap} = '0;
		rng = 64'd42;
		rst_n_in = 1'b0;
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		check(64'(mmu_on), 64'h0);
		check(64'(vec_sp), 64'(space_decode_pkg::SPACE_ROOT));
		check(64'(vec_addr), 64'(`VECTOR_RESET));
		reg_read(`ADDR_CTRL, `CTRL_RESET, '1);
		reg_read(4'h9, 32'h0, '1);
		reg_write(2'h1, `ADDR_SECCFG, 32'h7);
		reg_read(`ADDR_SECCFG, `SECCFG_RESET, '1);
		// Random vector captured once; the random source moves every edge
		vec_w = rng[31:0];
		reg_write(2'h3, `ADDR_VECTOR, vec_w);
		reg_read(`ADDR_VECTOR, vec_w, '1);
		check(64'(vec_addr), 64'(vec_w));
		reg_write(2'h3, `ADDR_CTRL, 32'h1);
		check(64'(mmu_on), 64'h1);
		// Reset request: refused below the top level, one pulse at it
		reg_write(2'h1, `ADDR_RESET_REQ, 32'h1);
		reg_read(`ADDR_STATUS, 32'h2, 32'h2);
		reg_read(`ADDR_STATUS, 32'h0, 32'h2);
		q_rst.push_back('{64'h1, '1});
		reg_write(2'h3, `ADDR_RESET_REQ, 32'h1);
		// Table descriptors with the reserved top bit set
		for (int r = 0; r < 8; r++) begin
			if (r != 1 && r != 7) begin
				walk(b63, r, 1'b1, 1'b0, mk(r == 5 ? space_decode_pkg::SPACE_ROOT
					: (r inside {[2:4]} ? sp_rl : sp_ns), 0, 0, 1), 6'h39);
			end
		end
		walk(b63, 0, 1'b1, 1'b1, mk(sp_ns, 0, 0, 1), 6'h39);
		walk(b63, 1, 1'b1, 1'b1, mk(space_decode_pkg::SPACE_SECURE, 0, 0, 1), 6'h39);
		// Leaf select bits, each clear and set
		for (int b = 0; b < 2; b++) begin
			walk(b ? b55 : 0, 2, 0, 1, mk(b ? sp_ns : sp_rl, 0, 0, 0), 6'h38);
			walk(b ? b55 : 0, 0, 0, 1, mk(sp_ns, 0, 0, 0), 6'h38);
			walk(b ? 64'h20 : 0, 3, 0, 0, mk(b ? sp_ns : sp_rl, 0, 0, 0), 6'h38);
			walk(b ? 64'h20 : 0, 4, 0, 0, mk(b ? sp_ns : sp_rl, 0, 0, 0), 6'h38);
			walk(b ? 64'h20 : 0, 2, 0, 0, mk(sp_rl, 0, 0, b), 6'h39);
			walk(b ? 64'h800 : 0, 4, 0, 0, mk(sp_rl, b, 0, 0), 6'h3c);
			walk(b ? 64'h800 : 0, 0, 0, 0, mk(sp_ns, b, 0, 0), 6'h3c);
		end
		for (int s = 0; s < 4; s++) begin
			walk({52'h0, s[1], 5'h0, s[0], 5'h0}, 5, 0, 0,
				mk(space_decode_pkg::space_e'(s), 0, s[1], 0), 6'h3a);
		end
		// Invalidation and translate ops under every top-level config
		tlb_invalidate_op(2'h1, sp_rl, sp_rl, 1'b1);
		for (int s = 0; s < 4; s++) begin
			reg_write(2'h3, `ADDR_SECCFG, 32'(s));
			tlb_invalidate_op(2'h3, space_decode_pkg::SPACE_ROOT, space_decode_pkg::space_e'(s), s != 2);
			for (int t = 0; t < 3; t++) begin
				at_op(2'h3, 2'(t), 0, 0, 0, 0, 0, s == 2 ? space_decode_pkg::AT_UNDEF
					: space_decode_pkg::AT_RECORD);
			end
		end
		reg_write(2'h3, `ADDR_SECCFG, 32'h0);
		at_op(2'h1, 2'h1, 1, 0, 0, 0, 0, space_decode_pkg::AT_EXCEPT);
		at_op(2'h1, 2'h1, 0, 0, 1, 0, 0, space_decode_pkg::AT_EXCEPT);
		for (int k = 0; k < 4; k++) begin
			at_op(2'h1, 2'h1, 0, 1, 0, 0, 2'(k), space_decode_pkg::AT_RECORD);
		end
		at_op(2'h1, 2'h1, 0, 0, 0, 1, 0, space_decode_pkg::AT_RECORD);
		reg_write(2'h3, `ADDR_SECCFG, 32'h4);
		at_op(2'h1, 2'h1, 0, 1, 0, 0, 0, space_decode_pkg::AT_EXCEPT);
		for (int i = 0; i < 50; i++) begin
			if (q_rd.size() + q_dec.size() + q_tlb_invalidate_op.size() + q_at.size() + q_rst.size() > 0) begin
				@(posedge clk_sys_in);
			end
		end
		if (q_rd.size() + q_dec.size() + q_tlb_invalidate_op.size() + q_at.size() + q_rst.size() > 0) begin
			mismatches++;
		end
		conclude();
	end
endmodule
